// ==== rtl/trle_cfg.svh ====
// Constants for the track list readout emulator
// Assumes inclusion by bare name from every design file
`ifndef TRLE_CFG_SVH
`define TRLE_CFG_SVH
`define TRLE_PHI 44
`define TRLE_PT 24
`define TRLE_GRP 4
`define TRLE_GBINS 6
`define TRLE_KEEP 6
`define TRLE_IDX_W 11
`define TRLE_ENC_W 3
`define TRLE_CELLS 1056
`define TRLE_CONN_BITS 512
`define TRLE_NBR_W 808
`define TRLE_HIT_W 1320
`define TRLE_CNT_W 80
`define TRLE_DIAG_W 1584
`define TRLE_TRK_W 264
`define TRLE_WORD_W 15
`define TRLE_VEC_W 4080
`define TRLE_DEPTH 32
`define TRLE_PTR_W 5
`define TRLE_WCNT_W 9
`define TRLE_N_NORM 9'h01f
`define TRLE_N_INP 9'h077
`define TRLE_N_DIAG 9'h110
`define TRLE_N_TEST 9'h081
`define TRLE_TEST_WORDS 9'h080
`define TRLE_OFF_CTRL 2'h0
`define TRLE_OFF_LAT 2'h1
`define TRLE_OFF_STAT 2'h2
`define TRLE_OFF_XCNT 2'h3
`define TRLE_MODE_RST 2'h0
`define TRLE_LAT_RST 5'h10
`define TRLE_LFSR_SEED 16'hace1
`define TRLE_LFSR_TAPS 16'hb400
`endif

// ==== rtl/trle_pkg.sv ====
// Types and shared functions of the track list readout emulator
// Assumes trle_cfg.svh is on the include path
`include "trle_cfg.svh"
package trle_pkg;
  // Chip mode codes as downloaded
  typedef enum logic [1:0] {
    TRLE_MODE_SPARSE = 2'h0,
    TRLE_MODE_NBR = 2'h1,
    TRLE_MODE_ALL = 2'h2,
    TRLE_MODE_UNDEF = 2'h3
  } trle_mode_t;
  // Readout levels
  typedef enum logic [1:0] {
    TRLE_LVL_NORMAL = 2'h0,
    TRLE_LVL_INPUT = 2'h1,
    TRLE_LVL_DIAG = 2'h2,
    TRLE_LVL_TEST = 2'h3
  } trle_lvl_t;
  typedef enum logic [2:0] {
    TRLE_S_IDLE = 3'b001,
    TRLE_S_ADDR = 3'b010,
    TRLE_S_DATA = 3'b100
  } trle_state_t;

  // Cell index, zero kept for empty
  function automatic logic [`TRLE_IDX_W-1:0] trle_cell_index(input int phi, input int pt);
    trle_cell_index = `TRLE_IDX_W'(phi * `TRLE_PT + pt + 1);
  endfunction : trle_cell_index

  function automatic trle_lvl_t trle_level(input trle_mode_t m);
    unique case (m)
      TRLE_MODE_SPARSE: trle_level = TRLE_LVL_NORMAL;
      TRLE_MODE_NBR: trle_level = TRLE_LVL_INPUT;
      TRLE_MODE_ALL: trle_level = TRLE_LVL_DIAG;
      TRLE_MODE_UNDEF: trle_level = TRLE_LVL_TEST;
    endcase
  endfunction : trle_level

  function automatic logic [`TRLE_WCNT_W-1:0] trle_len(input trle_lvl_t l);
    unique case (l)
      TRLE_LVL_NORMAL: trle_len = `TRLE_N_NORM;
      TRLE_LVL_INPUT: trle_len = `TRLE_N_INP;
      TRLE_LVL_DIAG: trle_len = `TRLE_N_DIAG;
      TRLE_LVL_TEST: trle_len = `TRLE_N_TEST;
    endcase
  endfunction : trle_len
endpackage : trle_pkg

// ==== rtl/trle_grp.sv ====
// One momentum group: per-phi priority encoder and first-six track scan
// Assumes flags arrive on the same clock, highest momentum at bin 0
`timescale 1ns/100ps
`include "trle_cfg.svh"
module trle_grp
  import trle_pkg::*;
#(
  parameter int GRP_ID = 0
) (
  // Clock
  input wire logic clk_i,
  // Group flags, phi-major, 6 bins per phi
  input wire logic [`TRLE_PHI*`TRLE_GBINS-1:0] flags_i,
  // Encoded column and kept tracks
  output logic [`TRLE_PHI*`TRLE_ENC_W-1:0] enc_o,
  output logic [`TRLE_KEEP*`TRLE_IDX_W-1:0] trk_o
);
  logic [`TRLE_PHI*`TRLE_ENC_W-1:0] enc_nxt;
  logic [`TRLE_KEEP*`TRLE_IDX_W-1:0] trk_nxt;

  always_comb begin
    logic [`TRLE_ENC_W-1:0] e;
    int n;
    e = '0;
    n = 0;
    enc_nxt = '0;
    trk_nxt = '0;
    for (int p = 0; p < `TRLE_PHI; p++) begin
      e = '0;
      // Highest momentum set flag wins, lower ones dropped
      for (int b = `TRLE_GBINS - 1; b >= 0; b--) begin
        if (flags_i[p*`TRLE_GBINS+b]) begin
          e = `TRLE_ENC_W'(b + 1);
        end
      end
      enc_nxt[p*`TRLE_ENC_W +: `TRLE_ENC_W] = e;
      // First six non-zero entries kept, rest lost
      if (e != '0 && n < `TRLE_KEEP) begin
        trk_nxt[n*`TRLE_IDX_W +: `TRLE_IDX_W] = trle_cell_index(p, GRP_ID * `TRLE_GBINS + int'(e) - 1);
        n++;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    enc_o <= enc_nxt;
    trk_o <= trk_nxt; // Unused slots stay zero
  end
endmodule : trle_grp

// ==== rtl/trle_top.sv ====
// Track list compaction, crossing pipeline and emulated readout chip
// Assumes classic Wishbone master and a byte-paced sequencer on pins
//
// Summary of operation
// - Matrix bit is one when a track was found for that phi and momentum bin.
// - Each matrix cell gets an index coding phi and momentum bin.
// - Matrix split into four momentum groups of 44 by 6, one unit each.
// - Per phi, only highest momentum set flag of a group is encoded.
// - First six non-zero indices of the column kept; further tracks dropped.
// - Sixty-four fresh hit bits per connector taken each crossing for track logic.
// - Readout data pipelined per crossing and shifted out like one readout chip.
// - Readout goes in byte pairs: address slot then data slot, top bit reserved.
// - Sixteen-bit word loses its msb; high byte to address, low to data.
// - Four readout levels: normal, input, diagnostic, test.
// - Normal: 24 tracks, 16 counts, status word; 496 bits.
// - Input level adds home and neighbour hits, 1408 bits.
// - Input hits held in a pipeline of up to 32 crossings.
// - Diagnostic level adds pipelined intermediate results, 2448 bits.
// - Test: 2 kbit test output plus status, raw inputs ignored, real chips off.
// - Undefined mode picks test; sparsify, neighbours, all pick normal, input, diagnostic.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "trle_cfg.svh"
module trle_top
  import trle_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Crossing marker and connector hits (pins)
  input wire logic xing_i,
  input wire logic [`TRLE_CONN_BITS-1:0] conn_hits_i,
  input wire logic [`TRLE_NBR_W-1:0] nbr_hits_i,
  // Track logic
  output logic [`TRLE_CONN_BITS-1:0] hit_o,
  input wire logic [`TRLE_CELLS-1:0] track_flags_i,
  input wire logic [`TRLE_CNT_W-1:0] counts_i,
  // Sequencer pins
  input wire logic seq_start_i,
  input wire logic seq_next_i,
  output logic [7:0] ro_byte_o,
  output logic ro_valid_o,
  output logic ro_addr_slot_o,
  output logic ro_busy_o,
  output logic real_off_o
);
  // Synchronisers
  logic xing_s1_r, xing_s2_r, xing_d_r;
  logic start_s1_r, start_s2_r, start_d_r;
  logic next_s1_r, next_s2_r, next_d_r;
  logic [`TRLE_CONN_BITS-1:0] conn_s1_r, conn_s2_r;
  logic [`TRLE_NBR_W-1:0] nbr_s1_r, nbr_s2_r;
  logic xing_p, start_p, next_p;

  always_ff @(posedge clk_i) begin
    xing_s1_r <= xing_i;
    xing_s2_r <= xing_s1_r;
    start_s1_r <= seq_start_i;
    start_s2_r <= start_s1_r;
    next_s1_r <= seq_next_i;
    next_s2_r <= next_s1_r;
    conn_s1_r <= conn_hits_i;
    conn_s2_r <= conn_s1_r;
    nbr_s1_r <= nbr_hits_i;
    nbr_s2_r <= nbr_s1_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xing_d_r <= 1'b0;
      start_d_r <= 1'b0;
      next_d_r <= 1'b0;
    end else begin
      xing_d_r <= xing_s2_r;
      start_d_r <= start_s2_r;
      next_d_r <= next_s2_r;
    end
  end

  assign xing_p = xing_s2_r & ~xing_d_r;
  assign start_p = start_s2_r & ~start_d_r;
  assign next_p = next_s2_r & ~next_d_r;

  // Registers
  trle_mode_t mode_r;
  logic [`TRLE_PTR_W-1:0] lat_r;
  logic [15:0] xcnt_r;
  trle_lvl_t lvl_cur;
  assign lvl_cur = trle_level(mode_r);

  // Crossing capture
  logic [`TRLE_CELLS-1:0] mtx_r;
  logic [`TRLE_CONN_BITS-1:0] hold_r;
  logic [`TRLE_NBR_W-1:0] nbr_r;
  logic [`TRLE_CNT_W-1:0] cnt_r;
  logic [1:0] wr_go_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_o <= '0;
      mtx_r <= '0;
      hold_r <= '0;
      nbr_r <= '0;
      cnt_r <= '0;
    end else if (xing_p) begin
      hit_o <= conn_s2_r;
      hold_r <= conn_s2_r;
      nbr_r <= nbr_s2_r;
      mtx_r <= track_flags_i;
      cnt_r <= counts_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_go_r <= 2'h0;
      xcnt_r <= 16'h0000;
    end else begin
      wr_go_r <= {wr_go_r[0], xing_p};
      xcnt_r <= xcnt_r + {15'h0000, xing_p};
    end
  end

  // Four momentum groups
  logic [`TRLE_GRP*`TRLE_PHI*`TRLE_ENC_W-1:0] enc_all;
  logic [`TRLE_TRK_W-1:0] trk_all;
  for (genvar g = 0; g < `TRLE_GRP; g++) begin : g_grp
    logic [`TRLE_PHI*`TRLE_GBINS-1:0] flags;
    for (genvar p = 0; p < `TRLE_PHI; p++) begin : g_phi
      assign flags[p*`TRLE_GBINS +: `TRLE_GBINS] = mtx_r[p*`TRLE_PT+g*`TRLE_GBINS +: `TRLE_GBINS];
    end
    trle_grp #(.GRP_ID(g)) u_grp (
      .clk_i(clk_i),
      .flags_i(flags),
      .enc_o(enc_all[g*`TRLE_PHI*`TRLE_ENC_W +: `TRLE_PHI*`TRLE_ENC_W]),
      .trk_o(trk_all[g*`TRLE_KEEP*`TRLE_IDX_W +: `TRLE_KEEP*`TRLE_IDX_W])
    );
  end

  // Crossing pipeline
  logic [`TRLE_TRK_W-1:0] p_trk [`TRLE_DEPTH];
  logic [`TRLE_CNT_W-1:0] p_cnt [`TRLE_DEPTH];
  logic [`TRLE_HIT_W-1:0] p_hit [`TRLE_DEPTH];
  logic [`TRLE_DIAG_W-1:0] p_diag [`TRLE_DEPTH];
  logic [`TRLE_PTR_W-1:0] wr_ptr_r;

  always_ff @(posedge clk_i) begin
    if (wr_go_r[1]) begin
      p_trk[wr_ptr_r] <= trk_all;
      p_cnt[wr_ptr_r] <= cnt_r;
      p_hit[wr_ptr_r] <= {nbr_r, hold_r};
      p_diag[wr_ptr_r] <= {mtx_r, enc_all};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
    end else if (wr_go_r[1]) begin
      wr_ptr_r <= wr_ptr_r + `TRLE_PTR_W'(1);
    end
  end

  // Snapshot assembly
  logic [`TRLE_PTR_W-1:0] rd_idx;
  logic [`TRLE_WORD_W-1:0] stat_w;
  logic [`TRLE_VEC_W-1:0] vec;
  logic [15*`TRLE_PT-1:0] trk_words;
  assign rd_idx = wr_ptr_r - lat_r;
  assign stat_w = {lvl_cur, mode_r, lat_r, wr_ptr_r, 1'b0};

  always_comb begin
    trk_words = '0;
    for (int i = 0; i < `TRLE_PT; i++) begin
      trk_words[i*`TRLE_WORD_W +: `TRLE_WORD_W] = {4'h0, p_trk[rd_idx][i*`TRLE_IDX_W +: `TRLE_IDX_W]};
    end
  end

  // Normal, then hits, then diagnostics
  assign vec = {711'h0, p_diag[rd_idx], p_hit[rd_idx], stat_w, 10'h000, p_cnt[rd_idx], trk_words};

  // Readout sequencer
  trle_state_t st_r;
  trle_lvl_t lvl_r;
  logic [`TRLE_VEC_W-1:0] snap_r;
  logic [`TRLE_WCNT_W-1:0] word_r;
  logic [15:0] lfsr_r;
  logic [`TRLE_WORD_W-1:0] stat_r, cur;
  logic last_word;

  always_comb begin
    if (lvl_r == TRLE_LVL_TEST) begin
      // Test output independent of raw inputs
      cur = (word_r < `TRLE_TEST_WORDS) ? lfsr_r[14:0] : stat_r;
    end else begin
      cur = snap_r[int'(word_r)*`TRLE_WORD_W +: `TRLE_WORD_W];
    end
  end
  assign last_word = (word_r + `TRLE_WCNT_W'(1)) == trle_len(lvl_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= TRLE_S_IDLE;
      lvl_r <= TRLE_LVL_NORMAL;
      word_r <= '0;
      stat_r <= '0;
      snap_r <= '0;
    end else begin
      unique case (st_r)
        TRLE_S_IDLE: begin
          if (start_p) begin
            st_r <= TRLE_S_ADDR;
            lvl_r <= lvl_cur;
            word_r <= '0;
            stat_r <= stat_w;
            snap_r <= vec;
          end
        end
        TRLE_S_ADDR: begin
          if (next_p) begin
            st_r <= TRLE_S_DATA;
          end
        end
        TRLE_S_DATA: begin
          if (next_p) begin
            if (last_word) begin
              st_r <= TRLE_S_IDLE;
            end else begin
              st_r <= TRLE_S_ADDR;
              word_r <= word_r + `TRLE_WCNT_W'(1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_r <= `TRLE_LFSR_SEED;
    end else if (st_r == TRLE_S_IDLE && start_p) begin
      lfsr_r <= `TRLE_LFSR_SEED;
    end else if (st_r == TRLE_S_DATA && next_p) begin
      lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? `TRLE_LFSR_TAPS : 16'h0000);
    end
  end

  // Byte outputs: reserved bit, then high or low part
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ro_byte_o <= 8'h00;
      ro_valid_o <= 1'b0;
      ro_addr_slot_o <= 1'b0;
      ro_busy_o <= 1'b0;
      real_off_o <= 1'b0;
    end else begin
      ro_byte_o <= (st_r == TRLE_S_ADDR) ? {1'b0, cur[14:8]} : cur[7:0];
      ro_valid_o <= (st_r != TRLE_S_IDLE);
      ro_addr_slot_o <= (st_r == TRLE_S_ADDR);
      ro_busy_o <= (st_r != TRLE_S_IDLE);
      real_off_o <= (lvl_cur == TRLE_LVL_TEST);
    end
  end

  // Wishbone slave, one wait state
  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= TRLE_MODE_SPARSE;
      lat_r <= `TRLE_LAT_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i[3:2] == `TRLE_OFF_CTRL) begin
        mode_r <= trle_mode_t'(wb_dat_i[1:0]);
      end
      if (wb_adr_i[3:2] == `TRLE_OFF_LAT) begin
        lat_r <= wb_dat_i[`TRLE_PTR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i[3:2])
          `TRLE_OFF_CTRL: wb_dat_o <= {30'h0, mode_r};
          `TRLE_OFF_LAT: wb_dat_o <= {27'h0, lat_r};
          `TRLE_OFF_STAT: wb_dat_o <= {13'h0, word_r, st_r, lvl_r, wr_ptr_r};
          `TRLE_OFF_XCNT: wb_dat_o <= {16'h0, xcnt_r};
        endcase
      end
    end
  end
endmodule : trle_top

// ==== dv/trle_top_assertions.sv ====
// Port checker of trle_top
// Assumes one clock, bound into every trle_top
`timescale 1ns/100ps
`include "trle_cfg.svh"
module trle_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic xing_i,
  input wire logic [`TRLE_CONN_BITS-1:0] hit_o,
  input wire logic seq_start_i,
  input wire logic [7:0] ro_byte_o,
  input wire logic ro_valid_o,
  input wire logic ro_addr_slot_o,
  input wire logic ro_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_rdat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_busy_same: assert property (ro_busy_o == ro_valid_o)
    else $error("busy and valid differ");
  chk_addr_top: assert property (ro_valid_o && ro_addr_slot_o |-> !ro_byte_o[7])
    else $error("address byte top bit set");
  chk_first_addr: assert property ($rose(ro_valid_o) |-> ro_addr_slot_o)
    else $error("readout not opened by address byte");
  chk_end_data: assert property ($fell(ro_valid_o) |-> !$past(ro_addr_slot_o))
    else $error("readout ended on address byte");
  chk_start_ans: assert property ($rose(seq_start_i) && !ro_busy_o |-> ##[1:8] ro_valid_o)
    else $error("start not answered");
  chk_hit_hold: assert property (!xing_i [*6] |=> $stable(hit_o))
    else $error("hits changed without crossing");
  cover property ($fell(ro_valid_o));
  cover property (ro_valid_o && !ro_addr_slot_o);
  cover property (wb_ack_o);
endmodule : trle_chk
bind trle_top trle_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xing_i(xing_i), .hit_o(hit_o), .seq_start_i(seq_start_i),
  .ro_byte_o(ro_byte_o), .ro_valid_o(ro_valid_o), .ro_addr_slot_o(ro_addr_slot_o), .ro_busy_o(ro_busy_o));

// ==== dv/trle_seq.sv ====
// Sequencer model: starts a readout and paces bytes
// Assumes the string holds only the emulated chip
`timescale 1ns/100ps
module trle_seq (
  // Clock
  input wire logic clk_i,
  // Readout pins
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  output logic start_o,
  output logic next_o
);
  logic [7:0] q [$];
  initial begin
    start_o = 1'b0;
    next_o = 1'b0;
  end
  // Full readout, gap cycles per pin phase; real chips not modelled
  task automatic run(input int gap);
    int n;
    n = 0;
    q.delete();
    start_o <= 1'b1;
    while (valid_i !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    start_o <= 1'b0;
    while (valid_i === 1'b1 && q.size() < 700) begin
      q.push_back(byte_i);
      next_o <= 1'b1;
      repeat (gap) @(posedge clk_i);
      next_o <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
  endtask : run
endmodule : trle_seq

// ==== dv/trle_top_tb.sv ====
// Bench of trle_top: registers, crossings, readout levels
// Assumes trle_seq partner and the bound checker
`timescale 1ns/100ps
`include "trle_cfg.svh"
module trle_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, xing_i;
  logic [3:0] wb_sel_i, wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic seq_start_i, seq_next_i, ro_valid_o, ro_addr_slot_o, ro_busy_o, real_off_o;
  logic [7:0] ro_byte_o;
  logic [511:0] conn_hits_i, hit_o;
  logic [807:0] nbr_hits_i;
  logic [1055:0] track_flags_i;
  logic [79:0] counts_i;
  logic [1319:0] hv;
  logic [15:0] lf;
  logic [14:0] w [$];
  int mismatches, checked, cyc_n, i, j, g, p, k, n, e, m, xc;
  int et [24];
  int nb [4] = '{496, 1904, 4352, 2064};
  trle_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .xing_i(xing_i), .conn_hits_i(conn_hits_i), .nbr_hits_i(nbr_hits_i), .hit_o(hit_o),
    .track_flags_i(track_flags_i), .counts_i(counts_i), .seq_start_i(seq_start_i), .seq_next_i(seq_next_i),
    .ro_byte_o(ro_byte_o), .ro_valid_o(ro_valid_o), .ro_addr_slot_o(ro_addr_slot_o), .ro_busy_o(ro_busy_o),
    .real_off_o(real_off_o));
  trle_seq seq_u (.clk_i(clk_i), .byte_i(ro_byte_o), .valid_i(ro_valid_o), .start_o(seq_start_i),
    .next_o(seq_next_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic cmp(input logic [511:0] a, input logic [511:0] b);
    checked++;
    if (a !== b) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, a, b);
    end
  endtask : cmp
  task automatic cmp_n(input int a, input int b);
    checked++;
    if (a != b) begin
      mismatches++;
      $display("wrong value at %0t: length %0d exp %0d", $time, a, b);
    end
  endtask : cmp_n
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: bus ack missing", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, xing_i} = 4'h0;
    {wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    {conn_hits_i, nbr_hits_i, track_flags_i, counts_i} = '0;
    void'($urandom(32'h0521));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0, 4'hf, r);
    cmp(r, 32'h0);
    wb(1'b1, 4'h8, 32'hffff, 4'hf, r);
    wb(1'b0, 4'h8, 32'h0, 4'hf, r);
    cmp(r, 32'h80);
    for (i = 0; i < 2; i++) begin
      wb(1'b1, 4'h4, 32'h1, {3'h7, i[0]}, r);
      wb(1'b0, 4'h4, 32'h0, 4'hf, r);
      cmp(r, i ? 32'h1 : 32'h10);
    end
    for (i = 0; i < 6; i++) begin
      m = i % 4;
      wb(1'b1, 4'h0, 32'(m), 4'hf, r);
      for (j = 0; j < 1056; j++) track_flags_i[j] <= ($urandom % (i % 2 ? 40 : 3)) == 0;
      for (j = 0; j < 1320; j++) hv[j] = 1'($urandom);
      conn_hits_i <= hv[511:0];
      nbr_hits_i <= hv[1319:512];
      counts_i <= 80'({$urandom, $urandom, $urandom});
      @(posedge clk_i);
      xing_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      xing_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      xc++;
      cmp(real_off_o, m == 3);
      if (m < 3) cmp(hit_o, hv[511:0]);
      for (g = 0; g < 4; g++) begin
        n = 0;
        for (p = 0; p < 44; p++) begin
          e = 0;
          for (k = 5; k >= 0; k--) if (track_flags_i[p*24+g*6+k]) e = p * 24 + g * 6 + k + 1;
          if (e != 0 && n < 6) et[g*6+n] = e;
          if (e != 0) n++;
        end
        for (; n < 6; n++) et[g*6+n] = 0;
      end
      seq_u.run(i < 4 ? 4 : 7);
      cmp_n(seq_u.q.size(), nb[m] / 8);
      w.delete();
      for (j = 0; j + 1 < seq_u.q.size(); j += 2) begin
        cmp(seq_u.q[j][7], 1'b0);
        w.push_back({seq_u.q[j][6:0], seq_u.q[j+1]});
      end
      cmp(w[m == 3 ? 128 : 30], {m[1:0], m[1:0], 5'h1, xc[4:0], 1'b0});
      if (m < 3) for (j = 0; j < 24; j++) cmp(w[j], et[j]);
      if (m < 3) for (j = 0; j < 80; j++) cmp(w[24 + j / 15][j % 15], counts_i[j]);
      if (m == 2) for (j = 0; j < 1056; j++) cmp(w[(2313 + j) / 15][(2313 + j) % 15], track_flags_i[j]);
      lf = `TRLE_LFSR_SEED;
      if (m == 3) for (j = 0; j < 128; j++) begin
        cmp(w[j], lf[14:0]);
        lf = {1'b0, lf[15:1]} ^ (lf[0] ? `TRLE_LFSR_TAPS : 16'h0000);
      end
      if (m inside {1, 2}) for (j = 0; j < 88; j++) cmp(w[31+j], hv[15*j+:15]);
    end
    wb(1'b0, 4'hc, 32'h0, 4'hf, r);
    cmp(r, 32'(xc));
    test_done();
  end
endmodule : trle_top_tb
